// ===== inc/capture_pkg.sv
// Purpose: constants, register map and mode codes of the timer input capture unit
// Assumes: one 200 MHz clock, synchronous active-high reset, AXI4-Lite with 32-bit data
// Notes:   every register holds one aligned word, narrow fields sit in the low bits
//
// What this block does
// (R1) A qualifying pin event copies the whole 16-bit timer count into the holding pair.
// (R2) Capture mode selects falling, rising, every 4th or every 16th rising edge.
// (R3) Each capture sets the event flag; only software clears it.
// (R4) A newer capture silently overwrites an unread held value.
// (R5) With the pin driven as output, port data changes can trigger captures.
// (R6) Software sets the pin direction bit to input for external edge sources.
// (R7) Timer must run in timer or synchronized counter mode for reliable captures.
// (R8) Mode changes may raise a false flag; software masks and clears it afterwards.
// (R9) Timer must use instruction clock or external clock, not the system clock; the code still offers SRC_FOSC, which counts every clk.
// (R10) Prescaler counter clears when off, not in capture mode, or on reset.
// (R11) Switching prescale settings directly keeps the counter; software clears control first.
// (R12) On instruction clock the timer holds during sleep and resumes afterwards.
// (R13) On external clock, detection, latching and flagging keep working in sleep.
// (R14) The pin is synchronised and edges found from successive samples.
// (R15) Divided settings count rising edges only and wrap to zero on capture.
////////////////////////////////////////////////////////////////////////////////
package capture_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_HOLD   = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK   = 8'h0C;
   localparam logic [7:0] OFF_PORT   = 8'h10;
   localparam logic [7:0] OFF_TIMER  = 8'h14;
   localparam logic [7:0] OFF_TCFG   = 8'h18;

   // capture_mode_select codes
   localparam logic [3:0] MODE_OFF    = 4'h0;
   localparam logic [3:0] MODE_FALL   = 4'h4;
   localparam logic [3:0] MODE_RISE   = 4'h5;
   localparam logic [3:0] MODE_RISE4  = 4'h6;
   localparam logic [3:0] MODE_RISE16 = 4'h7;

   // timer clock sources
   typedef enum logic [1:0] {
      SRC_INSTR = 2'h0,
      SRC_FOSC  = 2'h1,
      SRC_EXT   = 2'h2
   } timer_src_e;

   // field positions
   localparam int FLAG_BIT     = 0;
   localparam int PORT_DATA_BIT = 0;
   localparam int PORT_DIR_BIT = 1;
   localparam int TCFG_ON_BIT  = 2;

   // counts and bus response codes
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [3:0] DIV4_LAST      = 4'h3;
   localparam logic [3:0] DIV16_LAST     = 4'hF;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // true for the four capture settings
   function automatic logic is_capture_mode(input logic [3:0] m);
      return (m == MODE_FALL) || (m == MODE_RISE) || (m == MODE_RISE4) || (m == MODE_RISE16);
   endfunction : is_capture_mode

endpackage : capture_pkg

// ===== core/edge_prescaler.sv
// Purpose: turns sampled pin edges into capture strobes per capture mode
// Assumes: rise and fall are one-cycle pulses from the same clock
// Notes:   capture is a combinational strobe in the cycle of the edge
////////////////////////////////////////////////////////////////////////////////
module edge_prescaler (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       rise,
   input  wire logic       fall,
   input  wire logic [3:0] mode,
   output logic            capture
);

   typedef struct packed {
      logic [3:0] count;
   } presc_state_s;

   presc_state_s st_r;
   presc_state_s st_nxt;
   logic         active;
   logic         divided;
   logic [3:0]   lastIdx;

   // mode decode
   assign active  = capture_pkg::is_capture_mode(mode);
   assign divided = (mode == capture_pkg::MODE_RISE4) || (mode == capture_pkg::MODE_RISE16);
   assign lastIdx = (mode == capture_pkg::MODE_RISE4) ? capture_pkg::DIV4_LAST : capture_pkg::DIV16_LAST;

   // strobe selection
   always_comb begin
      capture = 1'b0;
      if (active) begin
         if (mode == capture_pkg::MODE_FALL) begin
            capture = fall; // R2
         end else if (mode == capture_pkg::MODE_RISE) begin
            capture = rise; // R2
         end else begin
            capture = rise && (st_r.count == lastIdx); // R2
         end
      end
   end

   // counter; a switch between divided settings keeps the count on purpose
   always_comb begin
      st_nxt = st_r;
      if (!active) begin
         st_nxt.count = 4'h0; // R10
      end else if (divided && rise) begin
         st_nxt.count = capture ? 4'h0 : st_r.count + 4'h1; // R15 R11
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0; // R10
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   presc_clear_a: assert property (!active |=> st_r.count == 4'h0) // R10
      else $error("prescaler not cleared outside capture");
   div_wrap_a: assert property (capture && divided |=> st_r.count == 4'h0) // R15
      else $error("prescaler did not wrap on capture");
   no_fall_count_a: assert property (divided && fall && !rise && $stable(mode) |=> $stable(st_r.count)) // R15
      else $error("prescaler moved on a falling edge");

endmodule : edge_prescaler

// ===== core/capture_unit.sv
// Purpose: input capture unit with its shared timer and AXI4-Lite registers
// Assumes: sleep comes from logic on clk; capture and external clock pins are asynchronous
// Notes:   capture latency from pin edge is three clocks through the synchroniser
////////////////////////////////////////////////////////////////////////////////
module capture_unit #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   input  wire logic              capturePinIn,
   output logic                   capturePinOut,
   output logic                   capturePinOe,
   input  wire logic              extClkIn,
   input  wire logic              sleep,
   output logic                   irq
);

   typedef struct packed {
      logic              awHeld;
      logic [ADDR_W-1:0] awAddr;
      logic              wHeld;
      logic [31:0]       wData;
      logic [3:0]        wStrb;
      logic              bValid;
      logic [1:0]        bResp;
      logic              rValid;
      logic [31:0]       rData;
      logic [1:0]        rResp;
      logic [3:0]        mode;
      logic [15:0]       hold;
      logic              flag;
      logic              irqEn;
      logic              pinDirIn;
      logic              portData;
      logic [1:0]        clkSrc;
      logic              timerOn;
      logic [15:0]       timer;
      logic [1:0]        instrDiv;
      logic              pinS1;
      logic              pinS2;
      logic              levelPrev;
      logic              extS1;
      logic              extS2;
      logic              extPrev;
   } unit_state_s;

   localparam unit_state_s RESET_STATE = '{pinDirIn: 1'b1, default: '0};

   unit_state_s st_r;
   unit_state_s st_nxt;
   logic        doWrite;
   logic        pinLevel;
   logic        pinRise;
   logic        pinFall;
   logic        extRise;
   logic        instrTick;
   logic        timerTick;
   logic        capPulse;
   logic        wrTimer;
   logic        wrStatus;
   logic [31:0] merged;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // address hit on an aligned word
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return {a[7:2], 2'b00} == off;
   endfunction : hit

   // readable view of every register, shared by read path and write merge
   function automatic logic [31:0] reg_word(input unit_state_s s, input logic [ADDR_W-1:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (hit(a, capture_pkg::OFF_CTRL)) begin
         r = {28'h000_0000, s.mode};
      end else if (hit(a, capture_pkg::OFF_HOLD)) begin
         r = {16'h0000, s.hold};
      end else if (hit(a, capture_pkg::OFF_STATUS)) begin
         r = {31'h0000_0000, s.flag};
      end else if (hit(a, capture_pkg::OFF_MASK)) begin
         r = {31'h0000_0000, s.irqEn};
      end else if (hit(a, capture_pkg::OFF_PORT)) begin
         r = {30'h0000_0000, s.pinDirIn, s.portData};
      end else if (hit(a, capture_pkg::OFF_TIMER)) begin
         r = {16'h0000, s.timer};
      end else if (hit(a, capture_pkg::OFF_TCFG)) begin
         r = {29'h0000_0000, s.timerOn, s.clkSrc};
      end
      return r;
   endfunction : reg_word

   // true for any mapped offset
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return hit(a, capture_pkg::OFF_CTRL) || hit(a, capture_pkg::OFF_HOLD) ||
             hit(a, capture_pkg::OFF_STATUS) || hit(a, capture_pkg::OFF_MASK) ||
             hit(a, capture_pkg::OFF_PORT) || hit(a, capture_pkg::OFF_TIMER) ||
             hit(a, capture_pkg::OFF_TCFG);
   endfunction : mapped

   // byte-lane merge of new data over old word
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////
   // edge detection and timer tick

   // pin sees the port latch while driven, so port writes act as edges
   assign pinLevel = st_r.pinDirIn ? st_r.pinS2 : st_r.portData; // R5
   assign pinRise  = pinLevel && !st_r.levelPrev; // R14
   assign pinFall  = !pinLevel && st_r.levelPrev; // R14
   assign extRise  = st_r.extS2 && !st_r.extPrev;

   // instruction clock is clk/4; both internal sources stop in sleep
   assign instrTick = st_r.instrDiv == capture_pkg::INSTR_DIV_LAST;
   assign timerTick = st_r.timerOn &&
                      ((st_r.clkSrc == capture_pkg::SRC_EXT) ? extRise : // R13
                       (!sleep && ((st_r.clkSrc == capture_pkg::SRC_FOSC) || instrTick))); // R12

   edge_prescaler u_presc (
      .clk     (clk),
      .rst     (rst),
      .rise    (pinRise),
      .fall    (pinFall),
      .mode    (st_r.mode),
      .capture (capPulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus handshakes and write decode

   assign awready  = !st_r.awHeld && !st_r.bValid;
   assign wready   = !st_r.wHeld && !st_r.bValid;
   assign arready  = !st_r.rValid;
   assign doWrite  = st_r.awHeld && st_r.wHeld && !st_r.bValid;
   assign merged   = merge(reg_word(st_r, st_r.awAddr), st_r.wData, st_r.wStrb);
   assign wrTimer  = doWrite && hit(st_r.awAddr, capture_pkg::OFF_TIMER) && (st_r.wStrb[1:0] != 2'h0);
   assign wrStatus = doWrite && hit(st_r.awAddr, capture_pkg::OFF_STATUS) && st_r.wStrb[0];

   // outputs straight from state
   assign bvalid        = st_r.bValid;
   assign bresp         = st_r.bResp;
   assign rvalid        = st_r.rValid;
   assign rdata         = st_r.rData;
   assign rresp         = st_r.rResp;
   assign capturePinOut = st_r.portData;
   assign capturePinOe  = !st_r.pinDirIn; // R6
   assign irq           = st_r.flag && st_r.irqEn;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_nxt = st_r;
      // synchronisers; first stage feeds only the second
      st_nxt.pinS1     = capturePinIn; // R14
      st_nxt.pinS2     = st_r.pinS1; // R14
      st_nxt.levelPrev = pinLevel; // R14
      st_nxt.extS1     = extClkIn;
      st_nxt.extS2     = st_r.extS1;
      st_nxt.extPrev   = st_r.extS2;
      // write address and data, in either order
      if (awvalid && awready) begin
         st_nxt.awHeld = 1'b1;
         st_nxt.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         st_nxt.wHeld = 1'b1;
         st_nxt.wData = wdata;
         st_nxt.wStrb = wstrb;
      end
      if (st_r.bValid && bready) begin
         st_nxt.bValid = 1'b0;
      end
      // register writes; mode change leaves the flag alone, software clears it
      if (doWrite) begin
         st_nxt.awHeld = 1'b0;
         st_nxt.wHeld  = 1'b0;
         st_nxt.bValid = 1'b1;
         st_nxt.bResp  = mapped(st_r.awAddr) ? capture_pkg::RESP_OKAY : capture_pkg::RESP_SLVERR;
         if (hit(st_r.awAddr, capture_pkg::OFF_CTRL)) begin
            st_nxt.mode = merged[3:0]; // R8 R11
         end else if (hit(st_r.awAddr, capture_pkg::OFF_HOLD)) begin
            st_nxt.hold = merged[15:0];
         end else if (hit(st_r.awAddr, capture_pkg::OFF_MASK)) begin
            st_nxt.irqEn = merged[0];
         end else if (hit(st_r.awAddr, capture_pkg::OFF_PORT)) begin
            st_nxt.portData = merged[capture_pkg::PORT_DATA_BIT];
            st_nxt.pinDirIn = merged[capture_pkg::PORT_DIR_BIT];
         end else if (hit(st_r.awAddr, capture_pkg::OFF_TCFG)) begin
            st_nxt.clkSrc  = merged[1:0];
            st_nxt.timerOn = merged[capture_pkg::TCFG_ON_BIT];
         end
      end
      // flag clear by writing one
      if (wrStatus && st_r.wData[capture_pkg::FLAG_BIT]) begin
         st_nxt.flag = 1'b0;
      end
      // read channel
      if (st_r.rValid && rready) begin
         st_nxt.rValid = 1'b0;
      end
      if (arvalid && arready) begin
         st_nxt.rValid = 1'b1;
         st_nxt.rData  = reg_word(st_r, araddr);
         st_nxt.rResp  = mapped(araddr) ? capture_pkg::RESP_OKAY : capture_pkg::RESP_SLVERR;
      end
      // timer; divider halts in sleep so the count resumes where it stopped
      if (!sleep) begin
         st_nxt.instrDiv = st_r.instrDiv + 2'h1; // R12
      end
      if (wrTimer) begin
         st_nxt.timer = merged[15:0];
      end else if (timerTick) begin
         st_nxt.timer = st_r.timer + 16'h0001; // R12 R13
      end
      // capture beats a same-cycle bus write or flag clear
      if (capPulse) begin
         st_nxt.hold = st_r.timer; // R1 R4
         st_nxt.flag = 1'b1; // R3
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= RESET_STATE;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   capture_copy_a: assert property (capPulse |=> st_r.hold == $past(st_r.timer)) // R1
      else $error("held value is not the timer at capture");

   flag_set_a: assert property (capPulse |=> st_r.flag) // R3
      else $error("flag not set by capture");

   flag_sticky_a: assert property (st_r.flag && !wrStatus |=> st_r.flag) // R3
      else $error("flag dropped without software clear");

   overwrite_a: assert property (capPulse ##1 capPulse |=> st_r.hold == $past(st_r.timer) && st_r.flag) // R4
      else $error("second capture did not overwrite");

   port_edge_a: assert property ((st_r.mode == capture_pkg::MODE_RISE) && !st_r.pinDirIn && $stable(st_r.pinDirIn)
                                 && $rose(st_r.portData) |-> capPulse) // R5
      else $error("port write edge did not capture");

   fall_mode_a: assert property ((st_r.mode == capture_pkg::MODE_FALL) && pinRise |-> !capPulse) // R2
      else $error("rising edge captured in falling mode");

   pin_latency_a: assert property ((st_r.mode == capture_pkg::MODE_RISE) && st_r.pinDirIn && $stable(st_r.mode)
                                   && $rose(st_r.pinS2) && $stable(st_r.pinDirIn) |-> capPulse) // R14
      else $error("synchronised rising edge missed");

   off_quiet_a: assert property (!capture_pkg::is_capture_mode(st_r.mode) |-> !capPulse) // R10
      else $error("capture outside capture mode");

   sleep_hold_a: assert property (sleep && (st_r.clkSrc == capture_pkg::SRC_INSTR) && !wrTimer
                                  |=> $stable(st_r.timer)) // R12
      else $error("timer moved in sleep on instruction clock");

   sleep_ext_a: assert property (sleep && (st_r.clkSrc == capture_pkg::SRC_EXT) && st_r.timerOn && extRise
                                 && !wrTimer |=> st_r.timer == $past(st_r.timer) + 16'h0001) // R13
      else $error("timer stopped in sleep on external clock");

   div4_span_a: assert property ((st_r.mode == capture_pkg::MODE_RISE4) && capPulse ##1
                                 ((st_r.mode == capture_pkg::MODE_RISE4) && !pinRise)[*2]
                                 |-> !capPulse) // R15
      else $error("divide-by-four captured without edges");

   write_resp_a: assert property (doWrite |=> bvalid)
      else $error("write not answered");

   cover_div16_c: cover property ((st_r.mode == capture_pkg::MODE_RISE16) && capPulse);
   cover_port_c: cover property (!st_r.pinDirIn && capPulse);
   cover_sleep_c: cover property (sleep && (st_r.clkSrc == capture_pkg::SRC_EXT) && capPulse);
   cover_clear_c: cover property (wrStatus && capPulse);

endmodule : capture_unit

// ===== test/pin_source.sv
// Purpose: external signal source that drives the capture pin
// Assumes: the pin is asynchronous to the unit clock
// Notes:   slow mode lands the change well off the clock grid
////////////////////////////////////////////////////////////////////////////////
module pin_source (
   input  wire logic lvl,
   input  wire logic slow,
   output logic      pin
);
   timeunit 1ns;
   timeprecision 100ps;

   initial pin = 1'b0;

   // follow the requested level, promptly or late; async so the synchroniser is exercised
   always @(lvl) begin
      if (slow) begin
         #7.3;
      end else begin
         #0.7;
      end
      pin = lvl;
   end
endmodule : pin_source

// ===== test/timer_input_capture_unit_test.sv
// Purpose: self-checking bench of the timer input capture unit
// Assumes: pin_source model on the capture pin, AXI4-Lite master tasks below
// Notes:   timer is stopped while captures are checked so held values are exact
////////////////////////////////////////////////////////////////////////////////
module timer_input_capture_unit_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, capturePinOut, capturePinOe;
   logic        extClkIn, sleep, irq, srcLvl, srcSlow, srcPin;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, lfsr;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   wire         capturePinIn;
   int          num_errors, n_checks;
   logic [3:0]  modes [4] = '{capture_pkg::MODE_FALL, capture_pkg::MODE_RISE,
                              capture_pkg::MODE_RISE4, capture_pkg::MODE_RISE16};

   // pin level: the unit when it drives, the source otherwise
   assign capturePinIn = capturePinOe ? capturePinOut : srcPin;

   capture_unit #(.ADDR_W(8)) DUT (.clk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready,
      .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
      .rdata, .rresp, .capturePinIn, .capturePinOut, .capturePinOe, .extClkIn, .sleep, .irq);
   pin_source src (.lvl(srcLvl), .slow(srcSlow), .pin(srcPin));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   // edges per capture for a mode
   function automatic int divOf(input logic [3:0] m);
      return (m == capture_pkg::MODE_RISE4) ? 4 : (m == capture_pkg::MODE_RISE16) ? 16 : 1;
   endfunction : divOf

   // falling mode latches the value written between the rise and the fall
   function automatic logic [31:0] expHold(input logic [3:0] m);
      return 32'(divOf(m)) + ((m == capture_pkg::MODE_FALL) ? 32'h8000 : 32'h0);
   endfunction : expHold

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
         num_errors++;
      end
   endtask : chk

   // write: address and data offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aT, wT, bT;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(negedge clk);
         aT = awvalid && awready;
         wT = wvalid && wready;
         bT = (bvalid === 1'b1);
         r  = bresp;
         @(posedge clk);
         if (aT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
      end while (!bT);
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic aT, rT;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(negedge clk);
         aT = arvalid && arready;
         rT = (rvalid === 1'b1);
         d  = rdata;
         r  = rresp;
         @(posedge clk);
         if (aT) arvalid <= 1'b0;
      end while (!rT);
      rready <= 1'b0;
   endtask : axr

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk(d, exp, msg);
   endtask : rd

   // move the source level, at random promptly or late, then let the capture settle
   task automatic setPin(input logic v);
      logic [31:0] x;
      x = rnd();
      @(posedge clk);
      srcLvl  <= v;
      srcSlow <= x[0];
      repeat (12) @(posedge clk);
   endtask : setPin

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   // free-running 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // watchdog, far beyond the few thousand cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   // main sequence
   initial begin
      logic [31:0] v, t1;
      logic [1:0]  r;
      {rst, awvalid, wvalid, bready, arvalid, rready, extClkIn, sleep, srcLvl, srcSlow} = 10'h200;
      {awaddr, araddr, wdata, wstrb} = '0;
      lfsr = 32'h8F07A7E4;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(capture_pkg::OFF_PORT, 32'h2, "port reset");
      rd(capture_pkg::OFF_CTRL, 32'h0, "ctrl reset");
      chk({31'h0, capturePinOe}, 32'h0, "pin released");
      axr(8'h40, v, r);
      chk({30'h0, r}, {30'h0, capture_pkg::RESP_SLVERR}, "unmapped read");
      axw(8'h40, 32'h1, r);
      chk({30'h0, r}, {30'h0, capture_pkg::RESP_SLVERR}, "unmapped write");
      wr(capture_pkg::OFF_TCFG, 32'h0);
      $display("test reset done");
      // every mode: leftover edges, clear by turning off, then exact prescaled count
      foreach (modes[i]) begin
         t1 = rnd();
         wr(capture_pkg::OFF_CTRL, 32'(modes[i]));
         repeat (t1[1:0] + 1) begin
            setPin(1'b1);
            setPin(1'b0);
         end
         wr(capture_pkg::OFF_CTRL, 32'h0);
         wr(capture_pkg::OFF_CTRL, 32'(modes[i]));
         wr(capture_pkg::OFF_STATUS, 32'h1);
         for (int k = 1; k <= divOf(modes[i]); k++) begin
            wr(capture_pkg::OFF_TIMER, 32'(k));
            setPin(1'b1);
            wr(capture_pkg::OFF_TIMER, 32'(k) | 32'h8000);
            setPin(1'b0);
            rd(capture_pkg::OFF_STATUS, {31'h0, k == divOf(modes[i])}, "flag per event");
         end
         rd(capture_pkg::OFF_HOLD, expHold(modes[i]), "held count");
      end
      $display("test modes done");
      // code 3, outside the capture set, neither captures nor flags
      wr(capture_pkg::OFF_CTRL, 32'h3);
      wr(capture_pkg::OFF_STATUS, 32'h1);
      setPin(1'b1);
      setPin(1'b0);
      rd(capture_pkg::OFF_STATUS, 32'h0, "no capture when off");
      // code 3 captures no edges at all, so go back to every rise
      wr(capture_pkg::OFF_CTRL, 32'(capture_pkg::MODE_RISE));
      // random full counts, second capture overwrites the unread first
      repeat (3) begin
         t1 = rnd();
         v = {16'h0, t1[15:0]};
         wr(capture_pkg::OFF_TIMER, ~v);
         setPin(1'b1);
         setPin(1'b0);
         wr(capture_pkg::OFF_TIMER, v);
         setPin(1'b1);
         setPin(1'b0);
         rd(capture_pkg::OFF_HOLD, v, "full count");
      end
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(capture_pkg::OFF_MASK, 32'h1);
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(capture_pkg::OFF_STATUS, 32'h0);
      rd(capture_pkg::OFF_STATUS, 32'h1, "flag sticky");
      wr(capture_pkg::OFF_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      rd(capture_pkg::OFF_STATUS, 32'h0, "flag cleared");
      $display("test flag done");
      // pin driven by the port: a data write makes the edge
      wr(capture_pkg::OFF_PORT, 32'h0);
      chk({31'h0, capturePinOe}, 32'h1, "pin driven");
      t1 = rnd();
      v = {16'h0, t1[15:0]};
      wr(capture_pkg::OFF_TIMER, v);
      wr(capture_pkg::OFF_PORT, 32'h1);
      repeat (8) @(posedge clk);
      chk({31'h0, capturePinOut}, 32'h1, "port data out");
      rd(capture_pkg::OFF_HOLD, v, "port capture");
      wr(capture_pkg::OFF_PORT, 32'h2);
      $display("test port done");
      // instruction clock: count frozen in sleep, resumes on wake
      wr(capture_pkg::OFF_TIMER, 32'h0);
      wr(capture_pkg::OFF_TCFG, 32'h4);
      @(posedge clk);
      sleep <= 1'b1;
      axr(capture_pkg::OFF_TIMER, t1, r);
      repeat (40) @(posedge clk);
      rd(capture_pkg::OFF_TIMER, t1, "frozen in sleep");
      sleep <= 1'b0;
      repeat (40) @(posedge clk);
      axr(capture_pkg::OFF_TIMER, v, r);
      chk({31'h0, v > t1}, 32'h1, "resumed");
      // system clock source counts every clock while awake
      wr(capture_pkg::OFF_TCFG, 32'h5);
      axr(capture_pkg::OFF_TIMER, t1, r);
      axr(capture_pkg::OFF_TIMER, v, r);
      chk({31'h0, v > t1}, 32'h1, "system clock counts");
      // external clock: counting and capture go on in sleep
      wr(capture_pkg::OFF_TCFG, 32'h6);
      wr(capture_pkg::OFF_TIMER, 32'h0);
      wr(capture_pkg::OFF_STATUS, 32'h1);
      sleep <= 1'b1;
      repeat (5) begin
         @(posedge clk);
         extClkIn <= 1'b1;
         repeat (4) @(posedge clk);
         extClkIn <= 1'b0;
         repeat (4) @(posedge clk);
      end
      setPin(1'b1);
      rd(capture_pkg::OFF_HOLD, 32'h5, "capture in sleep");
      rd(capture_pkg::OFF_STATUS, 32'h1, "flag in sleep");
      sleep <= 1'b0;
      $display("test sleep done");
      wrap_up();
   end
endmodule : timer_input_capture_unit_test
